//--- hw/tyag_top.sv
`timescale 1ns/1ps
`default_nettype none
module tyag_top #(
	parameter int HOLDOFF_CYCLES = tyag_pkg::TYAG_HOLDOFF_CYCLES
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// Avalon-MM slave
	input wire logic [tyag_pkg::TYAG_ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Transmit framer side
	input wire tyag_pkg::tyag_frm_type framing_mode_i,
	input wire logic dl_strobe_i,
	output logic bit2_force_o,
	output logic fs12_force_o,
	output logic ybit_force_o,
	output logic dl_override_o,
	output logic dl_bit_o
);
	import tyag_pkg::*;

	tyag_seq_if sq ();

	tyag_sel_type rai_format_select;
	logic alarm_send_control;
	logic req;
	logic [31:0] next_readdata;
	logic sf_or_n;

	tyag_rai_seq #(
		.HOLDOFF_CYCLES(HOLDOFF_CYCLES)
	) u_seq (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.sq(sq)
	);

	// Controls handed to the sequencer
	assign sq.sel = rai_format_select;
	assign sq.ctrl = alarm_send_control;
	assign sq.esf = (framing_mode_i == TYAG_FRM_ESF);
	assign sq.dl_strobe = dl_strobe_i;
	assign sf_or_n = (framing_mode_i == TYAG_FRM_SF) || (framing_mode_i == TYAG_FRM_N);
	assign req = avs_read_i | avs_write_i;

	// Read mux; unmapped addresses read as zero
	always_comb
	begin
		next_readdata = 32'h0000_0000;
		case (avs_address_i)
			TYAG_CTRL_ADDR:
			begin
				next_readdata[TYAG_SEND_BIT] = alarm_send_control;
				next_readdata[TYAG_SEL_LSB +: 2] = rai_format_select;
			end
			TYAG_STATUS_ADDR:
			begin
				next_readdata[TYAG_ST_SENDING_BIT] = sq.sending;
				next_readdata[TYAG_ST_HOLDOFF_BIT] = sq.holdoff;
				next_readdata[TYAG_ST_CNT_LSB +: 8] = sq.cw_cnt;
			end
			default:
				next_readdata = 32'h0000_0000;
		endcase
	end

	// One wait cycle per access, so read data is a registered copy
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h0000_0000;
		end
		else if (req && avs_waitrequest_o)
		begin
			avs_waitrequest_o <= 1'b0;
			avs_readdata_o <= next_readdata;
		end
		else
			avs_waitrequest_o <= 1'b1;
	end

	// Control register write, committed on the edge after the wait ends, as waitrequest returns high
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			alarm_send_control <= TYAG_CTRL_RESET[TYAG_SEND_BIT];
			rai_format_select <= tyag_sel_type'(TYAG_CTRL_RESET[TYAG_SEL_LSB +: 2]);
		end
		else if (avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
			&& avs_address_i == TYAG_CTRL_ADDR)
		begin
			alarm_send_control <= avs_writedata_i[TYAG_SEND_BIT];
			rai_format_select <= tyag_sel_type'(avs_writedata_i[TYAG_SEL_LSB +: 2]);
		end
	end

	// In-band alarm forces for SF, N and digital data framing
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			bit2_force_o <= 1'b0;
			fs12_force_o <= 1'b0;
			ybit_force_o <= 1'b0;
		end
		else
		begin
			// Selector zero never reaches any of these terms
			bit2_force_o <= alarm_send_control && sf_or_n
				&& (rai_format_select == TYAG_SEL_T1 || rai_format_select == TYAG_SEL_J1);
			fs12_force_o <= alarm_send_control && framing_mode_i == TYAG_FRM_SF
				&& rai_format_select == TYAG_SEL_LEVEL;
			ybit_force_o <= alarm_send_control && framing_mode_i == TYAG_FRM_DDF
				&& rai_format_select != TYAG_SEL_OFF;
		end
	end

	// Data link override; bit is registered, framer samples it at its strobe
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			dl_override_o <= 1'b0;
			dl_bit_o <= 1'b0;
		end
		else
		begin
			dl_override_o <= sq.sending;
			dl_bit_o <= sq.sending & sq.dl_bit;
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);

	// Selector zero held keeps every insertion off
	AST_SEL_OFF: assert property (
		(rai_format_select == TYAG_SEL_OFF)[*3]
		|=> !(bit2_force_o | fs12_force_o | ybit_force_o | dl_override_o))
		else $error("alarm inserted with selector zero");
	// Bit 2 forced in SF or N for selectors 01 and 11
	AST_BIT2: assert property (
		(alarm_send_control && sf_or_n && rai_format_select[0])
		|=> bit2_force_o && !ybit_force_o)
		else $error("bit 2 not forced in SF or N");
	// Y-bit driven low in digital data framing
	AST_YBIT: assert property (
		(alarm_send_control && framing_mode_i == TYAG_FRM_DDF
		&& rai_format_select != TYAG_SEL_OFF) |=> ybit_force_o && !bit2_force_o)
		else $error("Y-bit not forced");
	// Fs bit of frame 12 in SF with selector 10
	AST_FS12: assert property (
		(alarm_send_control && framing_mode_i == TYAG_FRM_SF
		&& rai_format_select == TYAG_SEL_LEVEL) |=> fs12_force_o && !bit2_force_o)
		else $error("Fs bit of frame 12 not set");
	// Selector 11 in N framing matches selector 01
	AST_SEL11_INBAND: assert property (
		(alarm_send_control && framing_mode_i == TYAG_FRM_N
		&& rai_format_select == TYAG_SEL_J1) |=> bit2_force_o && !fs12_force_o)
		else $error("selector 11 differs from 01");
	// Ones half then zeros half of the US codeword
	AST_T1_PATTERN: assert property (
		(sq.sending && rai_format_select == TYAG_SEL_T1)
		|=> dl_override_o && (dl_bit_o == !$past(sq.bit_idx[3])))
		else $error("wrong eight-ones eight-zeros bit");
	// Sixteen ones for the J1 codeword
	AST_J1_PATTERN: assert property (
		(sq.sending && rai_format_select == TYAG_SEL_J1) |=> dl_override_o && dl_bit_o)
		else $error("J1 codeword bit not one");
	// Bus answer comes one cycle after the request
	AST_BUS_WAIT: assert property (
		(req && avs_waitrequest_o) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
		else $error("wait request out of step");

	// Main scenarios
	COV_T1_ALARM: cover property (
		sq.sending && rai_format_select == TYAG_SEL_T1 ##1 sq.cw_cnt == 8'h02);
	COV_GAP: cover property (sq.holdoff);
	COV_LEVEL: cover property (sq.sending && rai_format_select == TYAG_SEL_LEVEL);
	COV_FS12: cover property (fs12_force_o);

endmodule // tyag_top
`default_nettype wire

//--- hw/tyag_pkg.sv
package tyag_pkg;

	// Register map, byte addresses on the slave port
	localparam int TYAG_ADDR_W = 12;
	localparam logic [11:0] TYAG_CTRL_ADDR = 12'h0108;
	localparam logic [11:0] TYAG_STATUS_ADDR = 12'h010c;

	// Control register fields and value after reset
	localparam int TYAG_SEND_BIT = 6;
	localparam int TYAG_SEL_LSB = 4;
	localparam logic [7:0] TYAG_CTRL_RESET = 8'h00;

	// Status register fields
	localparam int TYAG_ST_SENDING_BIT = 0;
	localparam int TYAG_ST_HOLDOFF_BIT = 1;
	localparam int TYAG_ST_CNT_LSB = 8;

	// Codeword framing on the 4 kbit/s data link
	localparam logic [7:0] TYAG_CW_COUNT = 8'hff;
	localparam logic [3:0] TYAG_CW_LAST_BIT = 4'hf;
	localparam logic [15:0] TYAG_PAT_T1 = 16'hff00;

	// Gap between two alarms, in its own unit and in clock cycles
	localparam int TYAG_HOLDOFF_MS = 1000;
	localparam int TYAG_CLK_KHZ = 250_000;
	localparam int TYAG_HOLDOFF_CYCLES = TYAG_HOLDOFF_MS * TYAG_CLK_KHZ;

	// Alarm format selector
	typedef enum logic [1:0] {
		TYAG_SEL_OFF = 2'b00,
		TYAG_SEL_T1 = 2'b01,
		TYAG_SEL_LEVEL = 2'b10,
		TYAG_SEL_J1 = 2'b11
	} tyag_sel_type;

	// Framing format of the transmit framer
	typedef enum logic [1:0] {
		TYAG_FRM_SF = 2'b00,
		TYAG_FRM_N = 2'b01,
		TYAG_FRM_ESF = 2'b10,
		TYAG_FRM_DDF = 2'b11
	} tyag_frm_type;

	// Codeword sequencer states, Gray along idle, send, hold
	typedef enum logic [1:0] {
		TYAG_ST_IDLE = 2'b00,
		TYAG_ST_SEND = 2'b01,
		TYAG_ST_HOLD = 2'b11
	} tyag_seq_state_type;

endpackage

//--- hw/tyag_seq_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tyag_seq_if;
	import tyag_pkg::*;

	// Controls from the register side
	tyag_sel_type sel;
	logic ctrl;
	logic esf;
	logic dl_strobe;
	// State of the codeword sequencer
	logic sending;
	logic holdoff;
	logic [3:0] bit_idx;
	logic dl_bit;
	logic [7:0] cw_cnt;

	modport ctl (output sel, ctrl, esf, dl_strobe,
		input sending, holdoff, bit_idx, dl_bit, cw_cnt);
	modport seq (input sel, ctrl, esf, dl_strobe,
		output sending, holdoff, bit_idx, dl_bit, cw_cnt);
endinterface
`default_nettype wire

//--- hw/tyag_rai_seq.sv
`timescale 1ns/1ps
`default_nettype none
module tyag_rai_seq #(
	parameter int HOLDOFF_CYCLES = tyag_pkg::TYAG_HOLDOFF_CYCLES
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// Register side
	tyag_seq_if.seq sq
);
	import tyag_pkg::*;

	localparam int GAP_W = $clog2(HOLDOFF_CYCLES + 1);

	tyag_seq_state_type state;
	logic ctrl_q;
	logic pending;
	logic [7:0] cnt;
	logic [3:0] bit_idx;
	logic [GAP_W-1:0] gap;
	logic ctrl_rise;
	logic live;
	logic timed;
	logic run_ok;
	logic cw_done;
	logic end_cond;
	logic start;

	// Decodes shared by the state and the counters
	assign ctrl_rise = sq.ctrl & ~ctrl_q;
	assign timed = (sq.sel == TYAG_SEL_T1) || (sq.sel == TYAG_SEL_J1);
	assign run_ok = sq.esf && (sq.sel != TYAG_SEL_OFF);
	assign cw_done = (state == TYAG_ST_SEND) && live && sq.dl_strobe
		&& (bit_idx == TYAG_CW_LAST_BIT);
	// Timed formats stop only after the full count and a low control bit
	assign end_cond = cw_done && !sq.ctrl && (!timed || (cnt >= TYAG_CW_COUNT - 8'h01));
	assign start = run_ok && (timed ? (ctrl_rise || pending) : sq.ctrl);

	// Edge detector on the send control bit
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			ctrl_q <= 1'b0;
		else
			ctrl_q <= sq.ctrl;
	end

	// Sequencer state
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			state <= TYAG_ST_IDLE;
		else
			case (state)
				TYAG_ST_IDLE:
					if (start)
						state <= TYAG_ST_SEND;
				TYAG_ST_SEND:
					if (!run_ok)
						state <= TYAG_ST_IDLE;
					else if (end_cond)
						state <= timed ? TYAG_ST_HOLD : TYAG_ST_IDLE;
				TYAG_ST_HOLD:
					if (!run_ok || gap == '0)
						state <= TYAG_ST_IDLE;
				default:
					state <= TYAG_ST_IDLE;
			endcase
	end

	// Slots count only once the override is on the line, else the first bit is lost
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			live <= 1'b0;
		else
			live <= (state == TYAG_ST_SEND);
	end

	// Request seen during the gap; the set wins over the clear
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			pending <= 1'b0;
		else if (state == TYAG_ST_HOLD && ctrl_rise && run_ok)
			pending <= 1'b1;
		else if (!run_ok || (state == TYAG_ST_IDLE && start))
			pending <= 1'b0;
	end

	// Gap counter, loaded as the timed alarm ends
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			gap <= '0;
		else if (state == TYAG_ST_SEND && end_cond && timed)
			gap <= GAP_W'(HOLDOFF_CYCLES - 1);
		else if (state == TYAG_ST_HOLD && gap != '0)
			gap <= gap - GAP_W'(1);
	end

	// Codeword counter; a fresh pulse restarts the count
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			cnt <= 8'h00;
		else if (state != TYAG_ST_SEND)
			cnt <= 8'h00;
		else if (ctrl_rise)
			cnt <= 8'h00;
		else if (cw_done && cnt != TYAG_CW_COUNT)
			cnt <= cnt + 8'h01;
	end

	// Bit position inside the 16-bit codeword
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			bit_idx <= 4'h0;
		else if (state != TYAG_ST_SEND)
			bit_idx <= 4'h0;
		else if (sq.dl_strobe && live)
			bit_idx <= bit_idx + 4'h1;
	end

	// Codeword bits go out first bit first, ones half leading
	assign sq.dl_bit = (sq.sel == TYAG_SEL_J1) ? 1'b1 : TYAG_PAT_T1[4'hf - bit_idx];
	assign sq.sending = (state == TYAG_ST_SEND);
	assign sq.holdoff = (state == TYAG_ST_HOLD);
	assign sq.bit_idx = bit_idx;
	assign sq.cw_cnt = cnt;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);

	// Timed alarm cannot end before the full count
	AST_MIN_COUNT: assert property (
		(state == TYAG_ST_SEND && run_ok && timed && cnt < TYAG_CW_COUNT - 8'h01)
		|=> state == TYAG_ST_SEND)
		else $error("timed alarm ended before 255 codewords");
	// Alarm runs on while the control bit is high
	AST_HELD_HIGH: assert property (
		(state == TYAG_ST_SEND && run_ok && sq.ctrl) |=> state == TYAG_ST_SEND)
		else $error("alarm stopped with control bit still high");
	// Level format stops at the first boundary after the bit drops
	AST_LEVEL_END: assert property (
		(cw_done && run_ok && sq.sel == TYAG_SEL_LEVEL && !sq.ctrl)
		|=> state == TYAG_ST_IDLE)
		else $error("level alarm outlived control bit");
	// Second pulse restarts the count
	AST_RESTART: assert property (
		(state == TYAG_ST_SEND && ctrl_rise) |=> cnt == 8'h00)
		else $error("codeword counter not restarted");
	// Leaving the gap only once it has run out
	AST_GAP_DONE: assert property (
		(state == TYAG_ST_HOLD && run_ok && gap != '0) |=> state == TYAG_ST_HOLD)
		else $error("gap left early");
	// Count moves only on a complete codeword
	AST_CW_STEP: assert property (
		(state == TYAG_ST_SEND && !$past(ctrl_rise) && $past(state) == TYAG_ST_SEND
		&& cnt != $past(cnt)) |-> $past(cw_done))
		else $error("codeword count moved off a boundary");

endmodule // tyag_rai_seq
`default_nettype wire

//--- hw/dummy_unused_none.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- tb/tyag_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module tyag_far_end (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// Line side
	input wire logic clear_i,
	input wire logic dl_override_i,
	input wire logic dl_bit_i,
	output logic dl_strobe_o,
	// Codeword tallies
	output logic [15:0] cw_t1_o,
	output logic [15:0] cw_j1_o,
	output logic [15:0] cw_bad_o
);
	logic [1:0] slot;
	logic [15:0] shift;
	logic [4:0] nbits;
	logic [15:0] word;

	// Slot every fourth cycle, above the two-cycle minimum
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			slot <= 2'h0;
		else
			slot <= slot + 2'h1;
	end
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			dl_strobe_o <= 1'b0;
		else
			dl_strobe_o <= (slot == 2'h3);
	end

	assign word = {shift[14:0], dl_bit_i};
	// Codewords assembled first bit first, sorted by pattern
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			shift <= 16'h0000;
			nbits <= 5'h00;
			cw_t1_o <= 16'h0000;
			cw_j1_o <= 16'h0000;
			cw_bad_o <= 16'h0000;
		end
		else if (clear_i)
		begin
			shift <= 16'h0000;
			nbits <= 5'h00;
			cw_t1_o <= 16'h0000;
			cw_j1_o <= 16'h0000;
			cw_bad_o <= 16'h0000;
		end
		else if (!dl_override_i)
			nbits <= 5'h00; // Realign on every new alarm
		else if (dl_strobe_o)
		begin
			shift <= word;
			nbits <= (nbits == 5'h0f) ? 5'h00 : nbits + 5'h01;
			if (nbits == 5'h0f && word == 16'hff00)
				cw_t1_o <= cw_t1_o + 16'h0001;
			else if (nbits == 5'h0f && word == 16'hffff)
				cw_j1_o <= cw_j1_o + 16'h0001;
			else if (nbits == 5'h0f)
				cw_bad_o <= cw_bad_o + 16'h0001;
		end
	end
endmodule // tyag_far_end
`default_nettype wire

//--- tb/tb_t1_yellow_alarm_generator.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
	$display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
`define WAITC(c, n) begin int w; w = 0; while (!(c) && w < (n)) begin \
	@(posedge mclk_i); w++; end `CHK(w < (n), 1'b1) end
module tb_t1_yellow_alarm_generator;
	import tyag_pkg::*;
	logic mclk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [11:0] avs_address_i = 12'h000;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0000_0000;
	logic [3:0] avs_byteenable_i = 4'hf;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	tyag_frm_type framing_mode_i = TYAG_FRM_SF;
	logic dl_strobe, bit2_force_o, fs12_force_o, ybit_force_o, dl_override_o, dl_bit_o;
	logic clear = 1'b0;
	logic [15:0] cw_t1, cw_j1, cw_bad;
	logic [31:0] rd;
	int num_errors = 0;
	int n_compared = 0;

	// Short gap keeps the run brief; checks use the same value
	tyag_top #(.HOLDOFF_CYCLES(50)) tyag_top_i (.mclk_i(mclk_i), .rstn_i(rstn_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .framing_mode_i(framing_mode_i),
		.dl_strobe_i(dl_strobe), .bit2_force_o(bit2_force_o),
		.fs12_force_o(fs12_force_o), .ybit_force_o(ybit_force_o),
		.dl_override_o(dl_override_o), .dl_bit_o(dl_bit_o));
	tyag_far_end tyag_far_end_i (.mclk_i(mclk_i), .rstn_i(rstn_i), .clear_i(clear),
		.dl_override_i(dl_override_o), .dl_bit_i(dl_bit_o), .dl_strobe_o(dl_strobe),
		.cw_t1_o(cw_t1), .cw_j1_o(cw_j1), .cw_bad_o(cw_bad));

	// Clock, 4 ns period
	always #2 mclk_i = ~mclk_i;

	// Request held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		avs_address_i <= a;
		avs_writedata_i <= {24'h00_0000, d};
		avs_write_i <= wr;
		avs_read_i <= !wr;
		`WAITC(avs_waitrequest_o === 1'b0, 20)
		rd = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask

	task automatic restart(input logic [7:0] d);
		@(posedge mclk_i);
		clear <= 1'b1;
		@(posedge mclk_i);
		clear <= 1'b0;
		framing_mode_i <= TYAG_FRM_ESF;
		bus(1'b1, TYAG_CTRL_ADDR, d);
	endtask

	task automatic t_regs();
		// Idle levels right after reset release
		`CHK(avs_waitrequest_o, 1'b1)
		`CHK(dl_override_o, 1'b0)
		bus(1'b0, TYAG_CTRL_ADDR, 8'h00);
		`CHK(rd, 32'h0000_0000)
		bus(1'b0, 12'h0200, 8'h00);
		`CHK(rd, 32'h0000_0000)
		bus(1'b1, TYAG_CTRL_ADDR, 8'h30);
		bus(1'b0, TYAG_CTRL_ADDR, 8'h00);
		`CHK(rd, 32'h0000_0030)
		$display("test regs done");
	endtask

	// Every in-band framing against every selector value
	task automatic t_inband();
		for (int f = 0; f < 4; f++)
		begin
			for (int s = 0; s < 4; s++)
			begin
				if (f == 2)
					continue;
				framing_mode_i <= tyag_frm_type'(f);
				bus(1'b1, TYAG_CTRL_ADDR, 8'h40 | 8'(s << 4));
				repeat (3) @(posedge mclk_i);
				`CHK(bit2_force_o, f < 2 && s[0])
				`CHK(fs12_force_o, f == 0 && s == 2)
				`CHK(ybit_force_o, f == 3 && s != 0)
			end
		end
		bus(1'b1, TYAG_CTRL_ADDR, 8'h00);
		$display("test inband done");
	endtask

	// Short pulse, full count, then a request during the gap
	task automatic t_esf_timed();
		restart(8'h50);
		bus(1'b1, TYAG_CTRL_ADDR, 8'h10);
		`WAITC(dl_override_o === 1'b1, 20)
		`WAITC(dl_override_o === 1'b0, 20000)
		`CHK(cw_t1, 16'h00ff)
		`CHK(cw_bad, 16'h0000)
		bus(1'b0, TYAG_STATUS_ADDR, 8'h00);
		`CHK(rd[1:0], 2'b10)
		bus(1'b1, TYAG_CTRL_ADDR, 8'h50);
		repeat (25) @(posedge mclk_i);
		`CHK(dl_override_o, 1'b0)
		`WAITC(dl_override_o === 1'b1, 80)
		// Control held past the full count keeps the alarm going
		`WAITC(cw_t1 === 16'h0203, 20000)
		bus(1'b1, TYAG_CTRL_ADDR, 8'h00);
		repeat (3) @(posedge mclk_i);
		`CHK(dl_override_o, 1'b0)
		`CHK(cw_t1, 16'h0203)
		repeat (100) @(posedge mclk_i);
		$display("test esf timed done");
	endtask

	// Sixteen-ones alarm, pulsed again after fifty codewords
	task automatic t_esf_retrigger();
		restart(8'h70);
		bus(1'b1, TYAG_CTRL_ADDR, 8'h30);
		`WAITC(cw_j1 === 16'h0032, 5000)
		bus(1'b1, TYAG_CTRL_ADDR, 8'h70);
		bus(1'b1, TYAG_CTRL_ADDR, 8'h30);
		`WAITC(dl_override_o === 1'b0, 20000)
		`CHK(cw_j1, 16'h0131)
		`CHK(cw_bad, 16'h0000)
		repeat (100) @(posedge mclk_i);
		$display("test esf retrigger done");
	endtask

	// Level alarm ends at the boundary after the drop, no gap
	task automatic t_esf_level();
		restart(8'h60);
		`WAITC(cw_t1 === 16'h000a, 2000)
		bus(1'b1, TYAG_CTRL_ADDR, 8'h20);
		`WAITC(dl_override_o === 1'b0, 200)
		`CHK(cw_t1, 16'h000b)
		bus(1'b0, TYAG_STATUS_ADDR, 8'h00);
		`CHK(rd[1:0], 2'b00)
		$display("test esf level done");
	endtask

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		repeat (4) @(posedge mclk_i);
		rstn_i <= 1'b1;
		t_regs();
		t_inband();
		t_esf_timed();
		t_esf_retrigger();
		t_esf_level();
		wrap_up();
	end

	// Watchdog at 70000 cycles, above the expected 54000
	initial
	begin
		#280_000;
		num_errors++;
		wrap_up();
	end
endmodule // tb_t1_yellow_alarm_generator
`default_nettype wire
